// ===== hdl/tfe_frame_encoder.sv
// Purpose: telemetry frame encoder, commutator, framing and sync channel
// Assumes: sequencer clocks arrive as synchronous levels
// Notes:   analog mixing is outside; adc gives 7-bit codes
//
// Contract
// [R1] four bit rates 4096/2048/1024/128, chosen by sequencer command
// [R2] selected bit rate is reported to data automation unit
// [R3] mode command from sequencer or automation unit changes mode
// [R4] analog samples are seven-bit codes, 128 levels
// [R5] commutator multiplexes analog, discrete and binary inputs
// [R6] main frame is 64 seven-bit words, 448 bits
// [R7] 64 main frames form a prime frame of 28672 bits
// [R8] sample rates scale with selected bit rate
// [R9] all timing comes from sequencer bit-rate clocks only
// [R10] 21-bit frame sync: barker then two complements
// [R11] channel 04 carries subcommutator deck position
// [R12] channel 03 carries format, rate and redundancy word
// [R13] shift-register pn generator, 63-chip period
// [R14] pn xor sync subcarrier forms sync channel
// [R15] word sync at register state 100000
// [R16] bit sync every ninth pn chip from word sync
// [R17] seven bit-sync states in listed order
// [R18] each bit sync shifts one data bit out
// [R19] test port: modulation, four serial, word and frame sync
// [R20] sequencer supplies pn, sync and data subcarrier clocks
// [R21] binary sources send nrz data only in gated slot
// [R22] five science-mode discretes plus bit, word, frame rate signals
// [R23] pn generator advances once per pn clock cycle
// [R24] barker 1110010, complement 0001101 twice, msb first
`timescale 1ns/100ps
module tfe_frame_encoder
   import tfe_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pn_clk_in,
   input  wire logic       sync_sc_in,
   input  wire logic       data_sc_in,
   input  wire logic       rate_cmd_valid,
   input  wire logic [1:0] rate_cmd,
   input  wire logic       seq_mode_valid,
   input  wire logic [2:0] seq_mode_cmd,
   input  wire logic       dau_mode_valid,
   input  wire logic [2:0] dau_mode_cmd,
   input  wire logic       redund_sel,
   input  wire logic [6:0] adc_code,
   input  wire logic [7:0] discrete_in,
   input  wire logic       binary_in,
   output logic      [5:0] mux_sel_r,
   output logic            binary_gate_r,
   output logic            data_bit_r,
   output logic            sync_chan_r,
   output logic            data_chan_r,
   output logic            mod_out_r,
   output logic      [3:0] test_serial_r,
   output logic            test_word_sync_r,
   output logic            test_frame_sync_r,
   output logic      [1:0] rate_ind_r,
   output logic      [2:0] mode_r,
   output logic      [4:0] sci_mode_r,
   output logic            bit_rate_r,
   output logic            word_rate_r,
   output logic            frame_rate_r
);
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [6:0] fmt_word(input logic [2:0] m, input logic [1:0] r, input logic red);
      fmt_word = {m, r, red, 1'b0};
   endfunction : fmt_word

   function automatic logic [4:0] sci_decode(input logic [2:0] m);
      sci_decode = 5'h00;
      if (m >= 3'h1 && m <= 3'h5)
         sci_decode[m - 3'h1] = 1'b1;
   endfunction : sci_decode

   logic       pn_clk_d_r;
   logic       pn_tick;
   logic [5:0] pn_state;
   logic       pn_chip;
   logic       word_sync;
   logic       bit_sync;
   logic [2:0] bit_idx_r;
   logic [5:0] word_idx_r;
   logic [5:0] deck_pos_r;
   logic [6:0] shift_r;
   logic [6:0] word_nxt;
   logic [5:0] load_idx;
   logic [1:0] rate_r;
   logic       first_word_r;

   // ************************************************************
   // timing from sequencer pn clock
   // ************************************************************
   assign pn_tick = pn_clk_in & ~pn_clk_d_r; // [R9]

   always_ff @(posedge clk)
   begin
      if (rst)
         pn_clk_d_r <= 1'b0;
      else
         pn_clk_d_r <= pn_clk_in;
   end

   tfe_pn_gen u_pn
   (
      .clk         (clk),
      .rst         (rst),
      .pn_tick     (pn_tick),
      .pn_state_r  (pn_state),
      .pn_chip_r   (pn_chip),
      .word_sync_r (word_sync),
      .bit_sync_r  (bit_sync)
   );

   // ************************************************************
   // rate and mode commands
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
         rate_r <= RATE_RESET;
      else if (rate_cmd_valid)
         rate_r <= rate_cmd; // [R1]
   end

   // sequencer wins a same-cycle conflict; it is the backup authority
   always_ff @(posedge clk)
   begin
      if (rst)
         mode_r <= MODE_RESET;
      else if (seq_mode_valid)
         mode_r <= seq_mode_cmd; // [R3]
      else if (dau_mode_valid)
         mode_r <= dau_mode_cmd; // [R3]
   end

   // ************************************************************
   // commutator counters
   // ************************************************************
   // sample rate follows the bit clock, so it scales with rate
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bit_idx_r    <= 3'h0;
         word_idx_r   <= 6'h00;
         deck_pos_r   <= 6'h00;
         first_word_r <= 1'b1;
      end
      else if (word_sync)
      begin
         bit_idx_r    <= 3'h0;
         first_word_r <= 1'b0;
         if (!first_word_r)
         begin
            word_idx_r <= word_idx_r + 6'h01; // [R6] [R8]
            if (word_idx_r == 6'(FRAME_WORDS - 1))
               deck_pos_r <= deck_pos_r + 6'h01; // [R7]
         end
      end
      else if (bit_sync)
         bit_idx_r <= bit_idx_r + 3'h1;
   end

   // ************************************************************
   // word content
   // ************************************************************
   // word sync loads the word being entered, not the one just sent
   assign load_idx = first_word_r ? 6'h00 : word_idx_r + 6'h01;

   always_comb
   begin
      case (load_idx)
         CH_SYNC0:  word_nxt = FRAME_SYNC[20:14]; // [R10] [R24]
         6'h01:     word_nxt = FRAME_SYNC[13:7];  // [R10]
         CH_SYNC2:  word_nxt = FRAME_SYNC[6:0];   // [R10]
         CH_FORMAT: word_nxt = fmt_word(mode_r, rate_r, redund_sel); // [R12]
         CH_SUBPOS: word_nxt = {1'b0, deck_pos_r}; // [R11]
         default:
         begin
            case (load_idx[1:0])
               2'h0:    word_nxt = adc_code; // [R4] [R5]
               2'h1:    word_nxt = discrete_in[6:0]; // [R5]
               2'h2:    word_nxt = {binary_in, 6'h00}; // [R5] [R21]
               default: word_nxt = adc_code;
            endcase
         end
      endcase
   end

   // ************************************************************
   // serializer on bit sync
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         shift_r    <= 7'h00;
         data_bit_r <= 1'b0;
      end
      else if (word_sync)
      begin
         shift_r    <= {word_nxt[5:0], 1'b0};
         data_bit_r <= word_nxt[6]; // [R18]
      end
      else if (bit_sync)
      begin
         shift_r    <= {shift_r[5:0], 1'b0};
         data_bit_r <= shift_r[6]; // [R18]
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mux_sel_r     <= 6'h00;
         binary_gate_r <= 1'b0;
      end
      else
      begin
         mux_sel_r     <= word_idx_r; // [R5]
         binary_gate_r <= (word_idx_r > CH_SUBPOS) && (word_idx_r[1:0] == 2'h2); // [R21]
      end
   end

   // ************************************************************
   // channel outputs and test port
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync_chan_r       <= 1'b0;
         data_chan_r       <= 1'b0;
         mod_out_r         <= 1'b0;
         test_serial_r     <= 4'h0;
         test_word_sync_r  <= 1'b0;
         test_frame_sync_r <= 1'b0;
      end
      else
      begin
         sync_chan_r       <= pn_chip ^ sync_sc_in; // [R14] [R20]
         data_chan_r       <= data_bit_r ^ data_sc_in;
         mod_out_r         <= (pn_chip ^ sync_sc_in) | (data_bit_r ^ data_sc_in); // [R19]
         test_serial_r     <= {4{data_bit_r}}; // [R19]
         test_word_sync_r  <= word_sync; // [R19]
         test_frame_sync_r <= word_sync && (word_idx_r == 6'(FRAME_WORDS - 1)); // [R19]
      end
   end

   // ************************************************************
   // outputs to data automation unit
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rate_ind_r   <= RATE_RESET;
         sci_mode_r   <= 5'h00;
         bit_rate_r   <= 1'b0;
         word_rate_r  <= 1'b0;
         frame_rate_r <= 1'b0;
      end
      else
      begin
         rate_ind_r   <= rate_r; // [R2]
         sci_mode_r   <= sci_decode(mode_r); // [R22]
         bit_rate_r   <= bit_sync; // [R22]
         word_rate_r  <= word_sync; // [R22]
         frame_rate_r <= word_sync && (word_idx_r == 6'(FRAME_WORDS - 1)); // [R22]
      end
   end
endmodule : tfe_frame_encoder

// ===== hdl/tfe_pkg.sv
// Purpose: constants for the telemetry frame encoder
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   frame layout, sync patterns and pn states
package tfe_pkg;
   // ************************************************************
   // frame layout
   // ************************************************************
   localparam int          WORD_BITS     = 7;
   localparam int          FRAME_WORDS   = 64;
   localparam int          FRAME_BITS    = 448;
   localparam int          PRIME_FRAMES  = 64;
   localparam int          PRIME_BITS    = 28672;
   localparam logic [5:0]  CH_SYNC0      = 6'h00;
   localparam logic [5:0]  CH_SYNC2      = 6'h02;
   localparam logic [5:0]  CH_FORMAT     = 6'h03;
   localparam logic [5:0]  CH_SUBPOS     = 6'h04;
   localparam logic [20:0] FRAME_SYNC    = 21'h1C868D;
   // ************************************************************
   // pseudo-noise generator
   // ************************************************************
   localparam int          PN_LEN        = 63;
   localparam int          PN_PER_BIT    = 9;
   localparam logic [5:0]  PN_SEED       = 6'h20;
   localparam logic [5:0]  PN_WORD_STATE = 6'h20;
   localparam logic [5:0]  PN_BIT_S1     = 6'h20;
   localparam logic [5:0]  PN_BIT_S2     = 6'h3A;
   localparam logic [5:0]  PN_BIT_S3     = 6'h26;
   localparam logic [5:0]  PN_BIT_S4     = 6'h1A;
   localparam logic [5:0]  PN_BIT_S5     = 6'h1C;
   localparam logic [5:0]  PN_BIT_S6     = 6'h3C;
   localparam logic [5:0]  PN_BIT_S7     = 6'h06;
   // ************************************************************
   // bit rates and modes
   // ************************************************************
   typedef enum logic [1:0]
   {
      TFE_R4096 = 2'b00,
      TFE_R2048 = 2'b01,
      TFE_R1024 = 2'b10,
      TFE_R128  = 2'b11
   } tfe_rate_e;
   localparam logic [2:0]  MODE_RESET    = 3'h0;
   localparam logic [1:0]  RATE_RESET    = 2'h1;
   localparam int          SCI_MODES     = 5;
endpackage : tfe_pkg

// ===== hdl/tfe_pn_gen.sv
// Purpose: 63-chip pseudo-noise generator with word and bit sync decode
// Assumes: pn_tick is a one-cycle pulse per pn clock cycle
// Notes:   sync flags are decoded combinationally then registered
`timescale 1ns/100ps
module tfe_pn_gen
   import tfe_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pn_tick,
   output logic      [5:0] pn_state_r,
   output logic            pn_chip_r,
   output logic            word_sync_r,
   output logic            bit_sync_r
);
   logic fb;
   logic is_bit;

   // x^6 + x + 1, maximal length; leading bit is shifted out next
   // these taps put the listed bit-sync states nine chips apart
   assign fb = pn_state_r[5] ^ pn_state_r[0];

   always_comb
   begin
      case (pn_state_r)
         PN_BIT_S1, PN_BIT_S2, PN_BIT_S3, PN_BIT_S4,
         PN_BIT_S5, PN_BIT_S6, PN_BIT_S7: is_bit = 1'b1; // [R17]
         default:                         is_bit = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         pn_state_r <= PN_SEED;
      else if (pn_tick)
         pn_state_r <= {pn_state_r[4:0], fb}; // [R13] [R23]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pn_chip_r   <= 1'b0;
         word_sync_r <= 1'b0;
         bit_sync_r  <= 1'b0;
      end
      else
      begin
         pn_chip_r   <= pn_tick ? pn_state_r[5] : pn_chip_r;
         word_sync_r <= pn_tick && (pn_state_r == PN_WORD_STATE); // [R15]
         bit_sync_r  <= pn_tick && is_bit; // [R16]
      end
   end
endmodule : tfe_pn_gen

// ===== sim/tfe_frame_checker.sv
// Purpose: port-level assertions for the frame encoder
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every encoder instance
`timescale 1ns/100ps
module tfe_frame_checker
(
   input logic       clk,
   input logic       rst,
   input logic       seq_mode_valid,
   input logic [2:0] seq_mode_cmd,
   input logic       dau_mode_valid,
   input logic [2:0] dau_mode_cmd,
   input logic       rate_cmd_valid,
   input logic [1:0] rate_cmd,
   input logic [2:0] mode_r,
   input logic [1:0] rate_ind_r,
   input logic [4:0] sci_mode_r,
   input logic [3:0] test_serial_r,
   input logic       data_bit_r,
   input logic       test_word_sync_r,
   input logic       word_rate_r,
   input logic [5:0] mux_sel_r
);
   // ******************************
   // properties
   // ******************************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire [4:0] sci_exp = (mode_r inside {[3'h1:3'h5]}) ? 5'h01 << (mode_r - 3'h1) : 5'h00;
   property p_seq_mode; seq_mode_valid |=> mode_r == $past(seq_mode_cmd); endproperty
   a_seq_mode: assert property (p_seq_mode) else $error("sequencer mode not taken");
   property p_dau_mode; dau_mode_valid && !seq_mode_valid |=> mode_r == $past(dau_mode_cmd); endproperty
   a_dau_mode: assert property (p_dau_mode) else $error("automation mode not taken");
   sequence s_rate_cmd; rate_cmd_valid ##1 !rate_cmd_valid; endsequence
   property p_rate_ind; s_rate_cmd |=> rate_ind_r == $past(rate_cmd, 2); endproperty
   a_rate_ind: assert property (p_rate_ind) else $error("rate indication wrong");
   property p_sci; $stable(mode_r) |-> sci_mode_r == sci_exp; endproperty
   a_sci: assert property (p_sci) else $error("science mode lines wrong");
   property p_serial; $stable(data_bit_r) |-> test_serial_r == {4{data_bit_r}}; endproperty
   a_serial: assert property (p_serial) else $error("test serial copies differ");
   property p_word_pulse; test_word_sync_r |=> !test_word_sync_r; endproperty
   a_word_pulse: assert property (p_word_pulse) else $error("word sync too long");
   property p_word_rate; word_rate_r |=> !word_rate_r [*8]; endproperty
   a_word_rate: assert property (p_word_rate) else $error("word rate pulses too close");
   property p_mux_step; $changed(mux_sel_r) |-> mux_sel_r == $past(mux_sel_r) + 6'h01; endproperty
   a_mux_step: assert property (p_mux_step) else $error("channel skipped");
endmodule : tfe_frame_checker
bind tfe_frame_encoder tfe_frame_checker chk_i (.clk, .rst, .seq_mode_valid, .seq_mode_cmd, .dau_mode_valid,
   .dau_mode_cmd, .rate_cmd_valid, .rate_cmd, .mode_r, .rate_ind_r, .sci_mode_r, .test_serial_r,
   .data_bit_r, .test_word_sync_r, .word_rate_r, .mux_sel_r);

// ===== sim/tfe_seq_model.sv
// Purpose: sequencer stand-in making pn and subcarrier clocks
// Assumes: rate code as on the encoder's rate command
// Notes:   clocks frozen while run is low
`timescale 1ns/100ps
module tfe_seq_model
(
   input  logic       clk,
   input  logic       run,
   input  logic [1:0] rate,
   output logic       pn_clk,
   output logic       sync_sc,
   output logic       data_sc
);
   // ******************************
   // divider
   // ******************************
   logic [8:0] cnt_r = 9'h000;
   logic [3:0] sh;
   // one divider keeps the three clocks in phase, as the sequencer must
   assign sh = (rate == 2'h3) ? 4'h5 : {2'h0, rate};
   always_ff @(posedge clk) if (run) cnt_r <= cnt_r + 9'h001;
   assign pn_clk  = cnt_r[sh + 4'h2];
   assign sync_sc = cnt_r[sh + 4'h1];
   assign data_sc = cnt_r[sh];
endmodule : tfe_seq_model

// ===== sim/tb_telemetry_frame_encoder.sv
// Purpose: self-checking bench for the frame encoder
// Assumes: pn clock of 8 system clocks at the top rate
// Notes:   words are read at mid-bit from the serial output
`timescale 1ns/100ps
module tb_telemetry_frame_encoder
   import tfe_pkg::*;
   ;
   logic       clk, rst, run, rate_cmd_valid, seq_mode_valid, dau_mode_valid, redund_sel, binary_in;
   logic [1:0] rate_cmd, rate_sel, rate_ind_r;
   logic [2:0] seq_mode_cmd, dau_mode_cmd, mode_r;
   logic [6:0] adc_code;
   logic [7:0] discrete_in;
   logic [5:0] mux_sel_r;
   logic [3:0] test_serial_r;
   logic [4:0] sci_mode_r;
   logic       pn_clk_in, sync_sc_in, data_sc_in, binary_gate_r, data_bit_r, sync_chan_r, data_chan_r;
   logic       mod_out_r, test_word_sync_r, test_frame_sync_r, bit_rate_r, word_rate_r, frame_rate_r;
   int         mismatches = 0, checks_done = 0, cyc = 0, fs_cnt = 0;
   tfe_frame_encoder dut (.clk, .rst, .pn_clk_in, .sync_sc_in, .data_sc_in, .rate_cmd_valid, .rate_cmd,
      .seq_mode_valid, .seq_mode_cmd, .dau_mode_valid, .dau_mode_cmd, .redund_sel, .adc_code,
      .discrete_in, .binary_in, .mux_sel_r, .binary_gate_r, .data_bit_r, .sync_chan_r, .data_chan_r,
      .mod_out_r, .test_serial_r, .test_word_sync_r, .test_frame_sync_r, .rate_ind_r, .mode_r,
      .sci_mode_r, .bit_rate_r, .word_rate_r, .frame_rate_r);
   tfe_seq_model seq (.clk, .run, .rate(rate_sel), .pn_clk(pn_clk_in), .sync_sc(sync_sc_in), .data_sc(data_sc_in));
   assign binary_in = binary_gate_r;
   // ******************************
   // helpers
   // ******************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (test_frame_sync_r === 1'b1) fs_cnt <= fs_cnt + 1;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic pulse(input logic rv, sv, dv, input logic [2:0] vs, vd);
      rate_cmd_valid = rv;
      seq_mode_valid = sv;
      dau_mode_valid = dv;
      rate_cmd = vs[1:0];
      seq_mode_cmd = vs;
      dau_mode_cmd = vd;
      @(negedge clk);
      rate_cmd_valid = 1'b0;
      seq_mode_valid = 1'b0;
      dau_mode_valid = 1'b0;
      @(negedge clk);
   endtask : pulse
   task automatic wsync;
      int n;
      n = 0;
      while (test_word_sync_r !== 1'b1 && n < 20000)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 20000) chk("word sync wait", 0, 1);
      @(negedge clk);
   endtask : wsync
   // ******************************
   // scenarios
   // ******************************
   task automatic t_modes;
      for (int m = 0; m < 8; m++)
      begin
         pulse(0, 1, 0, m[2:0], 3'h0);
         chk("seq mode", mode_r, 32'(m));
         chk("sci mode", sci_mode_r, (m >= 1 && m <= 5) ? 32'h1 << (m - 1) : 32'h0);
         pulse(0, 0, 1, 3'h0, 3'h7 - m[2:0]);
         chk("dau mode", mode_r, 32'(7 - m));
      end
      pulse(0, 1, 1, 3'h2, 3'h6);
      chk("seq wins", mode_r, 32'h2);
   endtask : t_modes
   task automatic t_frame;
      logic [6:0] w [69];
      logic [5:0] ch [69];
      for (int i = 0; i < 69; i++)
      begin
         wsync;
         for (int k = 6; k >= 0; k--)
         begin
            repeat (k == 6 ? 32 : 72) @(negedge clk);
            w[i][k] = data_bit_r;
         end
         ch[i] = mux_sel_r;
      end
      for (int i = 0; i < 69; i++) chk("channel", ch[i], 32'(i % 64));
      chk("sync word 0", w[0], 32'h72);
      chk("sync word 1", w[1], 32'h0D);
      chk("sync word 2", w[2], 32'h0D);
      chk("format word", w[3], 32'h52);
      chk("deck position", w[4], 32'h00);
      chk("discrete word", w[5], 32'h2A);
      chk("analog word", w[7], 32'h55);
      chk("next frame sync", w[64], 32'h72);
      chk("next deck position", w[68], 32'h01);
      chk("frame sync pulses", fs_cnt, 32'h1);
   endtask : t_frame
   task automatic t_rates;
      int t0;
      for (int r = 0; r < 4; r++)
      begin
         rate_sel = r[1:0];
         pulse(1, 0, 0, r[2:0], 3'h0);
         chk("rate indication", rate_ind_r, 32'(r));
         wsync;
         t0 = cyc;
         wsync;
         // word period is 63 pn chips, pn clock 8 system clocks at 4096
         chk("word period", 32'(cyc - t0), 32'(63 * (8 << (r == 3 ? 5 : r))));
      end
   endtask : t_rates
   initial
   begin
      rst = 1'b1;
      run = 1'b0;
      rate_sel = 2'h0;
      rate_cmd_valid = 1'b0;
      seq_mode_valid = 1'b0;
      dau_mode_valid = 1'b0;
      rate_cmd = 2'h0;
      seq_mode_cmd = 3'h0;
      dau_mode_cmd = 3'h0;
      redund_sel = 1'b1;
      adc_code = 7'h55;
      discrete_in = 8'h2A;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk("reset rate", rate_ind_r, 32'h1);
      chk("reset mode", mode_r, 32'h0);
      t_modes;
      pulse(1, 0, 1, 3'h0, 3'h5);
      run = 1'b1;
      t_frame;
      t_rates;
      results;
   end
   initial
   begin
      repeat (98000) @(posedge clk);
      mismatches++;
      results;
   end
endmodule : tb_telemetry_frame_encoder
